// [hw/gcd_cmd_decoder.sv]
`timescale 1ns/1ps
module gcd_cmd_decoder
   import gcd_pkg::*;
#(
   parameter bit REDUCED_VARIANT = 1'b0,
   parameter int NUM_FAULTS = 8,
   parameter logic [NUM_FAULTS-1:0] FAULT_RESETTABLE = 8'h7F,
   parameter longint FEED_CYCLES = FEED_CYCLES_DFLT
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic pdStrobe,
   input wire logic [15:0] command_word,
   input wire logic [7:0] travel_profile_select,
   input wire logic [7:0] recipe_index,
   input wire logic [15:0] expected_workpiece_position,
   input wire logic [7:0] gripForce,
   input wire logic [7:0] positionTolerance,
   input wire logic [15:0] actualPosition,
   input wire logic motionDone,
   input wire logic [NUM_FAULTS-1:0] faultRaw,
   output logic travel_outer,
   output logic travel_inner,
   output logic recalibrateStart,
   output logic outwardFast,
   output logic inwardFast,
   output logic postFeedActive,
   output logic [7:0] activeForce,
   output logic [7:0] activeTolerance,
   output logic [15:0] activeTeachPosition,
   output logic [NUM_FAULTS-1:0] faultActive,
   output logic [15:0] state_report_word
);
   initial begin
      if (NUM_FAULTS < 1 || NUM_FAULTS > 16) $error("gcd_cmd_decoder: bad NUM_FAULTS");
   end
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      gcd_state_t state;
      logic [15:0] lastCmd;
      logic accepted;
      logic dirOuter;
      logic dirInner;
      logic movedInner;
      logic [7:0] force_;
      logic [7:0] tol;
      logic [15:0] teach;
      logic [7:0] profile;
      logic outFast;
      logic inFast;
      logic goOuter;
      logic goInner;
      logic recal;
      logic [NUM_FAULTS-1:0] faults;
   } gcd_st_t;
   gcd_st_t st;
   gcd_st_t next_st;

   gcd_rcp_if rcp ();
   logic feedStart;
   logic take;
   logic cmdValid;
   logic idxStored;
   logic [RCP_AW-1:0] slot;

   function automatic logic profileOk(input logic [7:0] p);
      logic ok;
      ok = (p == PROF_OUT) || (p == PROF_IN) || (p == PROF_UNI);
      if (!REDUCED_VARIANT) begin
         ok = ok || (p == PROF_OUT_FEED) || (p == PROF_IN_FEED) || (p == PROF_UNI_FEED);
      end
      return ok;
   endfunction : profileOk

   // ------------------------------------------------------------
   // command acceptance
   // ------------------------------------------------------------
   // a word acts once, when it differs from the last word taken; this is
   // what lets the controller hold a command across several data cycles
   assign take = pdStrobe && (st.state == ST_IDLE) && (command_word != st.lastCmd);
   assign cmdValid = (command_word == CMD_NONE) ||
      ($onehot(command_word) && ((command_word & ~CMD_DEFINED) == 16'h0000));
   assign idxStored = (recipe_index != 8'h00) && (int'(recipe_index) <= RECIPE_MAX);
   assign slot = RCP_AW'(recipe_index - 8'h01);

   always_comb begin
      next_st = st;
      next_st.goOuter = 1'b0;
      next_st.goInner = 1'b0;
      next_st.recal = 1'b0;
      rcp.wrEn = 2'b00;
      rcp.rdEn = 1'b0;
      rcp.addr = slot;
      rcp.wrData = {expected_workpiece_position, positionTolerance, gripForce};
      // non-resettable faults follow their source, resettable ones latch
      next_st.faults = (st.faults & FAULT_RESETTABLE) | faultRaw;
      if (take) begin
         next_st.lastCmd = command_word;
      end
      if (take && cmdValid) begin
         unique case (command_word)
            CMD_NONE: next_st.accepted = 1'b0;
            CMD_LOAD: begin
               if (recipe_index == 8'h00) begin
                  next_st.force_ = gripForce;
                  next_st.tol = positionTolerance;
                  next_st.teach = expected_workpiece_position;
                  next_st.accepted = 1'b1;
               end else if (idxStored) begin
                  rcp.rdEn = 1'b1;
                  next_st.state = ST_READ;
               end
            end
            CMD_STORE: begin
               if (idxStored) rcp.wrEn = 2'b11;
            end
            CMD_CLRDIR: begin
               next_st.dirOuter = 1'b0;
               next_st.dirInner = 1'b0;
            end
            CMD_TEACH: begin
               rcp.wrData[RCP_TEACH_LSB +: 16] = actualPosition;
               if (idxStored) rcp.wrEn = 2'b10;
            end
            CMD_RECAL: next_st.recal = 1'b1;
            CMD_OUTER: begin
               if (!st.dirOuter) begin
                  next_st.goOuter = 1'b1;
                  next_st.dirOuter = 1'b1;
                  next_st.dirInner = 1'b0;
                  next_st.movedInner = 1'b0;
               end
            end
            CMD_INNER: begin
               if (!st.dirInner) begin
                  next_st.goInner = 1'b1;
                  next_st.dirInner = 1'b1;
                  next_st.dirOuter = 1'b0;
                  next_st.movedInner = 1'b1;
               end
            end
            // a still present source sets its bit again, so set wins
            CMD_FAULTACK: next_st.faults = faultRaw;
            default: next_st.state = st.state;
         endcase
      end
      case (st.state)
         ST_IDLE: next_st.state = next_st.state;
         ST_READ: next_st.state = ST_APPLY;
         ST_APPLY: begin
            next_st.force_ = rcp.rdData[7:0];
            next_st.tol = rcp.rdData[15:8];
            next_st.teach = rcp.rdData[RCP_TEACH_LSB +: 16];
            next_st.accepted = 1'b1;
            next_st.state = ST_IDLE;
         end
         default: next_st.state = ST_IDLE;
      endcase
      // ------------------------------------------------------------
      // travel profile
      // ------------------------------------------------------------
      if (profileOk(travel_profile_select)) begin
         next_st.profile = travel_profile_select;
      end
      next_st.outFast = (next_st.profile == PROF_OUT) ||
         (next_st.profile == PROF_OUT_FEED);
      next_st.inFast = (next_st.profile == PROF_IN) ||
         (next_st.profile == PROF_IN_FEED);
   end

   // feed follows the end of the last travel, inner for PROF_OUT_FEED, outer for PROF_IN_FEED, either for PROF_UNI_FEED
   assign feedStart = motionDone && (
      (st.profile == PROF_UNI_FEED) ||
      (st.profile == PROF_OUT_FEED && st.movedInner) ||
      (st.profile == PROF_IN_FEED && !st.movedInner));

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.state <= ST_IDLE;
         st.profile <= PROF_RESET;
         st.force_ <= FORCE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // submodules and outputs
   // ------------------------------------------------------------
   gcd_recipe_mem #(.DEPTH(RECIPE_MAX)) u_mem (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .rcp(rcp.mem)
   );
   gcd_feed_timer #(.CYCLES(FEED_CYCLES)) u_feed (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .start(feedStart),
      .active(postFeedActive)
   );

   assign travel_outer = st.goOuter;
   assign travel_inner = st.goInner;
   assign recalibrateStart = st.recal;
   assign outwardFast = st.outFast;
   assign inwardFast = st.inFast;
   assign activeForce = st.force_;
   assign activeTolerance = st.tol;
   assign activeTeachPosition = st.teach;
   assign faultActive = st.faults;
   always_comb begin
      state_report_word = 16'h0000;
      state_report_word[SR_PLC_ACTIVE] = 1'b1;
      state_report_word[SR_ACCEPTED] = st.accepted;
      state_report_word[SR_DIR_OUTER] = st.dirOuter;
      state_report_word[SR_DIR_INNER] = st.dirInner;
      state_report_word[SR_FAULT] = |st.faults;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_load_direct: assert property (
      take && command_word == CMD_LOAD && recipe_index == 8'h00
      |=> state_report_word[SR_ACCEPTED] && activeForce == $past(gripForce))
      else $error("direct load not applied");
   a_load_recipe: assert property (
      take && command_word == CMD_LOAD && idxStored
      |=> st.state == ST_READ ##1 st.state == ST_APPLY ##1 st.accepted)
      else $error("recipe load sequence broken");
   a_store_write: assert property (
      take && command_word == CMD_STORE && idxStored |-> rcp.wrEn == 2'b11 && rcp.addr == slot)
      else $error("recipe store missing");
   a_dir_clear: assert property (
      take && command_word == CMD_CLRDIR |=> !st.dirOuter && !st.dirInner)
      else $error("direction flag not cleared");
   a_teach_zero: assert property (
      take && command_word == CMD_TEACH && recipe_index == 8'h00 |-> rcp.wrEn == 2'b00)
      else $error("teach with zero index wrote");
   a_recal_pulse: assert property (
      take && command_word == CMD_RECAL |=> recalibrateStart ##1 !recalibrateStart)
      else $error("recalibration pulse wrong");
   a_outer_start: assert property (
      take && command_word == CMD_OUTER && !st.dirOuter
      |=> travel_outer && state_report_word[SR_DIR_OUTER])
      else $error("outer travel not started");
   a_inner_start: assert property (
      take && command_word == CMD_INNER && !st.dirInner
      |=> travel_inner && state_report_word[SR_DIR_INNER])
      else $error("inner travel not started");
   a_fault_ack: assert property (
      take && command_word == CMD_FAULTACK |=> (faultActive & ~$past(faultRaw)) == '0)
      else $error("fault acknowledge failed");
   a_ignore_bad: assert property (
      take && !cmdValid |-> rcp.wrEn == 2'b00 && !rcp.rdEn
      ##1 !travel_outer && !travel_inner && !recalibrateStart)
      else $error("invalid word acted");
   a_accept_clear: assert property (
      take && command_word == CMD_NONE |=> !state_report_word[SR_ACCEPTED])
      else $error("accepted bit not cleared");
   a_profile_speed: assert property (
      st.profile == PROF_UNI || st.profile == PROF_UNI_FEED |-> !outwardFast && !inwardFast)
      else $error("universal profile uses fast travel");
   a_profile_out: assert property (
      st.profile == PROF_OUT |-> outwardFast && !inwardFast)
      else $error("profile 60 speeds wrong");
   a_feed_start: assert property (
      motionDone && st.profile == PROF_UNI_FEED |=> postFeedActive)
      else $error("post-travel feed not started");
   a_reduced_prof: assert property (
      REDUCED_VARIANT |-> st.profile != PROF_OUT_FEED &&
      st.profile != PROF_IN_FEED && st.profile != PROF_UNI_FEED)
      else $error("feed profile on reduced variant");

   c_load_recipe: cover property (st.state == ST_APPLY);
   c_travel_in: cover property (travel_inner);
   c_feed: cover property (feedStart);
   c_bad_word: cover property (take && !cmdValid);
endmodule : gcd_cmd_decoder

// [hw/gcd_feed_timer.sv]
`timescale 1ns/1ps
module gcd_feed_timer #(
   parameter longint CYCLES = 1
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic start,
   output logic active
);
   localparam int CW = $clog2(CYCLES + 1);
   initial begin
      if (CYCLES < 1) $error("gcd_feed_timer: CYCLES must be at least 1");
   end
   typedef struct packed {
      logic [CW-1:0] count;
      logic active;
   } gcd_tmr_st_t;
   gcd_tmr_st_t st;
   gcd_tmr_st_t next_st;

   // a restart while running stretches the feed to a full period again
   always_comb begin
      next_st = st;
      if (start) begin
         next_st.count = CW'(CYCLES);
         next_st.active = 1'b1;
      end else if (st.count != '0) begin
         next_st.count = st.count - 1'b1;
         next_st.active = (st.count != CW'(1));
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign active = st.active;
endmodule : gcd_feed_timer

// [hw/gcd_recipe_mem.sv]
`timescale 1ns/1ps
module gcd_recipe_mem
   import gcd_pkg::*;
#(
   parameter int DEPTH = RECIPE_MAX
) (
   input wire logic clk_sys,
   input wire logic resetn,
   gcd_rcp_if.mem rcp
);
   initial begin
      if (DEPTH < 1 || DEPTH > (1 << RCP_AW)) $error("gcd_recipe_mem: bad DEPTH");
   end
   // ------------------------------------------------------------
   // storage, two independently written halves
   // ------------------------------------------------------------
   typedef struct packed {
      logic [RCP_DW-1:0] rdData;
   } gcd_mem_st_t;
   gcd_mem_st_t st;
   gcd_mem_st_t next_st;

   genvar h;
   generate
      for (h = 0; h < 2; h++) begin : g_half
         // each half owns its array; store writes both halves, teach writes only half 1
         logic [15:0] cells [DEPTH];
         always_ff @(posedge clk_sys) begin
            if (rcp.wrEn[h] && int'(rcp.addr) < DEPTH) begin
               cells[rcp.addr] <= rcp.wrData[h*16 +: 16];
            end
         end
      end
   endgenerate

   always_comb begin
      next_st = st;
      if (rcp.rdEn) begin
         next_st.rdData = (int'(rcp.addr) < DEPTH) ?
            {g_half[1].cells[rcp.addr], g_half[0].cells[rcp.addr]} : '0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign rcp.rdData = st.rdData;
endmodule : gcd_recipe_mem

// [inc/gcd_pkg.sv]
package gcd_pkg;
   // ------------------------------------------------------------
   // command word bits
   // ------------------------------------------------------------
   localparam logic [15:0] CMD_NONE = 16'h0000;
   localparam logic [15:0] CMD_LOAD = 16'h0001;
   localparam logic [15:0] CMD_STORE = 16'h0002;
   localparam logic [15:0] CMD_CLRDIR = 16'h0004;
   localparam logic [15:0] CMD_TEACH = 16'h0008;
   localparam logic [15:0] CMD_RECAL = 16'h0080;
   localparam logic [15:0] CMD_OUTER = 16'h0100;
   localparam logic [15:0] CMD_INNER = 16'h0200;
   localparam logic [15:0] CMD_FAULTACK = 16'h8000;
   localparam logic [15:0] CMD_DEFINED = 16'h838F;
   // ------------------------------------------------------------
   // travel profile codes
   // ------------------------------------------------------------
   localparam logic [7:0] PROF_OUT = 8'h3C;     // 60
   localparam logic [7:0] PROF_OUT_FEED = 8'h3F; // 63
   localparam logic [7:0] PROF_IN = 8'h46;      // 70
   localparam logic [7:0] PROF_IN_FEED = 8'h49;  // 73
   localparam logic [7:0] PROF_UNI = 8'h64;     // 100
   localparam logic [7:0] PROF_UNI_FEED = 8'h67; // 103
   localparam logic [7:0] PROF_RESET = 8'h64;
   // ------------------------------------------------------------
   // recipe store and state report layout
   // ------------------------------------------------------------
   localparam int RECIPE_MAX = 32;
   localparam int RCP_AW = 5;
   localparam int RCP_DW = 32;
   localparam int RCP_TEACH_LSB = 16;
   localparam int SR_PLC_ACTIVE = 6;
   localparam int SR_ACCEPTED = 12;
   localparam int SR_DIR_OUTER = 13;
   localparam int SR_DIR_INNER = 14;
   localparam int SR_FAULT = 15;
   localparam logic [7:0] FORCE_RESET = 8'h01;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam longint FEED_TIME_MS = 500;
   localparam longint CLK_PERIOD_PS = 4000;
   localparam longint FEED_CYCLES_DFLT = (FEED_TIME_MS * 64'd1000000000) / CLK_PERIOD_PS;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_APPLY = 2'b11
   } gcd_state_t;
endpackage : gcd_pkg

// [inc/gcd_rcp_if.sv]
`timescale 1ns/1ps
interface gcd_rcp_if;
   import gcd_pkg::*;
   logic [1:0] wrEn;
   logic rdEn;
   logic [RCP_AW-1:0] addr;
   logic [RCP_DW-1:0] wrData;
   logic [RCP_DW-1:0] rdData;
   modport ctrl (output wrEn, output rdEn, output addr, output wrData, input rdData);
   modport mem (input wrEn, input rdEn, input addr, input wrData, output rdData);
endinterface : gcd_rcp_if

// [tb/gcd_plc_model.sv]
`timescale 1ns/1ps
module gcd_plc_model
   import gcd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [15:0] state_report_word,
   output logic pdStrobe,
   output logic [15:0] command_word,
   output logic [7:0] travel_profile_select
);
   initial begin
      pdStrobe = 1'b0;
      command_word = CMD_NONE;
      travel_profile_select = PROF_UNI;
   end
   // ------------------------------------------------------------
   // cyclic process data
   // ------------------------------------------------------------
   // a malformed word or code only goes out when the caller insists on it
   task automatic send(input logic [15:0] w, input bit allowBad);
      bit legal;
      legal = (w == CMD_NONE) || (((w & ~CMD_DEFINED) == 16'h0000) && ($countones(w) == 1));
      @(posedge clk_sys);
      pdStrobe <= 1'b1;
      command_word <= (legal || allowBad) ? w : CMD_NONE;
      @(posedge clk_sys);
      pdStrobe <= 1'b0;
   endtask : send
   task automatic setProfile(input logic [7:0] code, input bit allowBad);
      bit legal;
      legal = code inside {PROF_OUT, PROF_OUT_FEED, PROF_IN, PROF_IN_FEED, PROF_UNI, PROF_UNI_FEED};
      @(posedge clk_sys);
      travel_profile_select <= (legal || allowBad) ? code : PROF_UNI;
   endtask : setProfile
   // load, wait for accepted, then all zeros and wait for it to drop
   task automatic handshake(output bit ok);
      int n;
      ok = 1'b0;
      send(CMD_LOAD, 1'b0);
      for (n = 0; n < 8 && state_report_word[SR_ACCEPTED] !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      if (state_report_word[SR_ACCEPTED] === 1'b1) begin
         send(CMD_NONE, 1'b0);
         for (n = 0; n < 8 && state_report_word[SR_ACCEPTED] !== 1'b0; n++) begin
            @(posedge clk_sys);
            #1;
         end
         ok = (state_report_word[SR_ACCEPTED] === 1'b0);
      end
   endtask : handshake
endmodule : gcd_plc_model

// [tb/gripper_command_decoder_bench.sv]
`timescale 1ns/1ps
module gripper_command_decoder_bench;
   import gcd_pkg::*;
   localparam int FEED_SIM = 20;
   logic clk_sys, resetn, pdStrobe, motionDone, travel_outer, travel_inner, recalibrateStart;
   logic outwardFast, inwardFast, postFeedActive, outR, inR;
   logic [15:0] command_word, expected_workpiece_position, actualPosition, activeTeachPosition;
   logic [15:0] state_report_word;
   logic [7:0] travel_profile_select, recipe_index, gripForce, positionTolerance, faultRaw;
   logic [7:0] activeForce, activeTolerance, faultActive;
   int n_mismatch = 0, compares = 0, cycles = 0, nOut = 0, nIn = 0, nRecal = 0, nFeed = 0;
   integer seed = 32'h20C9A275;
   logic [7:0] profTab[6] = '{PROF_OUT, PROF_OUT_FEED, PROF_IN, PROF_IN_FEED, PROF_UNI,
      PROF_UNI_FEED};
   logic [15:0] badWords[5] = '{16'h0180, 16'h0300, 16'h0081, 16'h0010, 16'h8001};
   bit feedDir[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

   gcd_plc_model plc_u (.clk_sys(clk_sys), .state_report_word(state_report_word),
      .pdStrobe(pdStrobe), .command_word(command_word),
      .travel_profile_select(travel_profile_select));
   gcd_cmd_decoder #(.FEED_CYCLES(longint'(FEED_SIM))) dut_u (.clk_sys(clk_sys),
      .resetn(resetn), .pdStrobe(pdStrobe), .command_word(command_word),
      .travel_profile_select(travel_profile_select), .recipe_index(recipe_index),
      .expected_workpiece_position(expected_workpiece_position), .gripForce(gripForce),
      .positionTolerance(positionTolerance), .actualPosition(actualPosition),
      .motionDone(motionDone), .faultRaw(faultRaw), .travel_outer(travel_outer),
      .travel_inner(travel_inner), .recalibrateStart(recalibrateStart),
      .outwardFast(outwardFast), .inwardFast(inwardFast), .postFeedActive(postFeedActive),
      .activeForce(activeForce), .activeTolerance(activeTolerance),
      .activeTeachPosition(activeTeachPosition), .faultActive(faultActive),
      .state_report_word(state_report_word));
   // reduced variant shares every input; only its speed outputs are judged
   gcd_cmd_decoder #(.REDUCED_VARIANT(1'b1), .FEED_CYCLES(longint'(FEED_SIM))) dut_r (
      .clk_sys(clk_sys), .resetn(resetn), .pdStrobe(pdStrobe), .command_word(command_word),
      .travel_profile_select(travel_profile_select), .recipe_index(recipe_index),
      .expected_workpiece_position(expected_workpiece_position), .gripForce(gripForce),
      .positionTolerance(positionTolerance), .actualPosition(actualPosition),
      .motionDone(motionDone), .faultRaw(faultRaw), .travel_outer(), .travel_inner(),
      .recalibrateStart(), .outwardFast(outR), .inwardFast(inR), .postFeedActive(),
      .activeForce(), .activeTolerance(), .activeTeachPosition(), .faultActive(),
      .state_report_word());

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (travel_outer === 1'b1) nOut <= nOut + 1;
      if (travel_inner === 1'b1) nIn <= nIn + 1;
      if (recalibrateStart === 1'b1) nRecal <= nRecal + 1;
      if (postFeedActive === 1'b1) nFeed <= nFeed + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         conclude();
      end
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s: seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic setData(input logic [7:0] idx, f, t, input logic [15:0] tp);
      @(posedge clk_sys);
      recipe_index <= idx;
      gripForce <= f;
      positionTolerance <= t;
      expected_workpiece_position <= tp;
   endtask : setData
   // {outwardFast, inwardFast}; refused codes keep what was there
   function automatic logic [1:0] expFast(input logic [7:0] c, input logic [1:0] p, input bit r);
      case (c)
         PROF_OUT: return 2'b10;
         PROF_IN: return 2'b01;
         PROF_UNI: return 2'b00;
         PROF_OUT_FEED: return r ? p : 2'b10;
         PROF_IN_FEED: return r ? p : 2'b01;
         PROF_UNI_FEED: return r ? p : 2'b00;
         default: return p;
      endcase
   endfunction : expFast
   function automatic int expFeed(input logic [7:0] c, input bit inner);
      if (c == PROF_UNI_FEED || (c == PROF_OUT_FEED && inner) || (c == PROF_IN_FEED && !inner))
         return FEED_SIM;
      return 0;
   endfunction : expFeed
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int i, k, base;
      logic [7:0] f, t, code;
      logic [15:0] tp, pos;
      logic [1:0] prevF, prevR;
      bit ok;
      resetn = 1'b0;
      motionDone = 1'b0;
      faultRaw = 8'h00;
      actualPosition = 16'h0000;
      setData(8'h00, 8'h01, 8'h00, 16'h0000);
      repeat (15) @(posedge clk_sys);
      resetn <= 1'b1;
      tick(1);
      check(state_report_word, 16'h0040, "report after reset");
      check({outwardFast, inwardFast}, 2'b00, "speeds after reset");
      base = nOut;
      plc_u.send(CMD_OUTER, 1'b0);
      #1;
      check(travel_outer, 1'b1, "outer pulse");
      check(state_report_word[14:13], 2'b01, "flag outer");
      tick(1);
      check(travel_outer, 1'b0, "outer pulse one cycle");
      plc_u.send(CMD_NONE, 1'b0);
      plc_u.send(CMD_OUTER, 1'b0);
      plc_u.send(CMD_CLRDIR, 1'b0);
      tick(2);
      check(nOut - base, 1, "repeat outer blocked");
      plc_u.send(CMD_OUTER, 1'b0);
      plc_u.send(CMD_INNER, 1'b0);
      #1;
      check(travel_inner, 1'b1, "inner pulse");
      check(state_report_word[14:13], 2'b10, "flag inner");
      check(nOut - base, 2, "outer after flag cleared");
      $display("test travel done");
      // let the inner pulse reach the counters before taking the base
      tick(1);
      base = nOut + nIn + nRecal;
      for (i = 0; i < 5; i++) plc_u.send(badWords[i], 1'b1);
      tick(3);
      check(nOut + nIn + nRecal - base, 0, "malformed words ignored");
      base = nRecal;
      plc_u.send(CMD_RECAL, 1'b0);
      tick(2);
      check(nRecal - base, 1, "recalibration");
      $display("test malformed and recalibrate done");
      for (i = 0; i < 3; i++) begin
         f = 8'($random(seed));
         t = 8'($random(seed));
         tp = 16'($random(seed));
         setData(8'h00, f, t, tp);
         plc_u.handshake(ok);
         check(ok, 1'b1, "accepted handshake");
         check({activeTeachPosition, activeTolerance, activeForce}, {tp, t, f}, "pd load");
      end
      for (i = 0; i < 2; i++) begin
         k = (i == 0) ? 32 : 1 + ($unsigned($random(seed)) % 31);
         setData(8'(k), f, t, tp);
         plc_u.send(CMD_STORE, 1'b0);
         pos = 16'($random(seed));
         @(posedge clk_sys);
         actualPosition <= pos;
         plc_u.send(CMD_TEACH, 1'b0);
         setData(8'h00, f, t, tp);
         @(posedge clk_sys);
         actualPosition <= ~pos;
         plc_u.send(CMD_NONE, 1'b0);
         plc_u.send(CMD_TEACH, 1'b0);
         setData(8'(k), ~f, ~t, ~tp);
         plc_u.handshake(ok);
         check({activeTeachPosition, activeTolerance, activeForce}, {pos, t, f}, "recipe");
      end
      $display("test datasets done");
      @(posedge clk_sys);
      faultRaw <= 8'h81;
      repeat (2) @(posedge clk_sys);
      faultRaw <= 8'h80;
      tick(2);
      check(faultActive, 8'h81, "faults held");
      plc_u.send(CMD_FAULTACK, 1'b0);
      tick(1);
      check(faultActive, 8'h80, "only resettable cleared");
      check(state_report_word[SR_FAULT], 1'b1, "fault bit");
      $display("test faults done");
      prevF = 2'b00;
      prevR = 2'b00;
      for (i = 0; i < 30; i++) begin
         code = (i < 6) ? profTab[i] : (i % 3 == 0) ? 8'($random(seed)) :
            profTab[$unsigned($random(seed)) % 6];
         plc_u.setProfile(code, 1'b1);
         tick(3);
         prevF = expFast(code, prevF, 1'b0);
         prevR = expFast(code, prevR, 1'b1);
         check({outwardFast, inwardFast}, prevF, "profile speeds");
         check({outR, inR}, prevR, "reduced variant speeds");
      end
      $display("test profiles done");
      for (i = 0; i < 6; i++) begin
         plc_u.setProfile(profTab[2 * (i / 2) + 1], 1'b0);
         plc_u.send(CMD_CLRDIR, 1'b0);
         plc_u.send(feedDir[i] ? CMD_INNER : CMD_OUTER, 1'b0);
         tick(2);
         base = nFeed;
         @(posedge clk_sys);
         motionDone <= 1'b1;
         @(posedge clk_sys);
         motionDone <= 1'b0;
         tick(FEED_SIM + 8);
         check(nFeed - base, expFeed(profTab[2 * (i / 2) + 1], feedDir[i]), "feed");
      end
      $display("test current feed done");
      conclude();
   end
endmodule : gripper_command_decoder_bench
